// *** ictm_map.svh ***
// Register map and fixed values of the interrupt controller.
//
// Behaviour
// R1 - Ten request lines, each with own flag.
// R2 - Every line has its own enable bit.
// R3 - Hardware sets flags; writing zero clears them.
// R4 - Edge select picks rising, falling or both.
// R5 - Global enable gates all lines.
// R6 - Flags still set while line disabled.
// R7 - Entry: push PC, stack+2, disable, vector 0x010.
// R8 - Return: pop PC, stack-2, enable, resume.
// R9 - Software keeps stack pointer bit 0 zero.
// R10 - Push and pop accumulator with flags together.
// R11 - Flags register readable to find the cause.
// R12 - Software clears only the serviced flag.
// R13 - Software reserves two stack bytes per level.
// R14 - Timer counts up; load and read instructions.
// R15 - Mode bits 7..5 select timer clock source.
// R16 - Mode bits 4..3 select prescaler 1/4/16/64.
// R17 - Mode bits 2..0 select tap bit 8..15.
// R18 - Selected tap edge raises timer request.
// R19 - Timer request sets flag bit 2.
// R20 - Timer mode register at index 0x06, read/write.
// R21 - Counter increments per tick, wraps at all ones.
`ifndef ICTM_MAP_SVH
`define ICTM_MAP_SVH

// Register indices; byte address is four times the index.
`define ICTM_IDX_LINE_EN 8'h04
`define ICTM_IDX_FLAGS 8'h05
`define ICTM_IDX_SIXTEEN_BIT_TIMER_MODE 8'h06
`define ICTM_IDX_EDGE_SEL 8'h07
`define ICTM_IDX_STACK_PTR 8'h08
`define ICTM_IDX_STATUS 8'h09
`define ICTM_IDX_COUNT 8'h0a

// Request line bit positions.
`define ICTM_NUM_LINES 10
`define ICTM_LINE_EXT0 0
`define ICTM_LINE_EXT1 1
`define ICTM_LINE_SIXTEEN_BIT_TIMER 2
`define ICTM_LINE_ADC 3
`define ICTM_LINE_TMR2 4
`define ICTM_LINE_TMR3_PWM2 5
`define ICTM_LINE_CMP_PWM1 6
`define ICTM_LINE_PWM0 7
`define ICTM_LINE_TOUCH_OVF 8
`define ICTM_LINE_TOUCH_DONE 9

// Edge select fields.
`define ICTM_EDGE_EXT0_LSB 0
`define ICTM_EDGE_EXT1_LSB 2
`define ICTM_EDGE_TIMER_FALL 4
`define ICTM_EDGE_EXT0_PINSEL 6
`define ICTM_EDGE_EXT1_PINSEL 7

// Timer mode fields.
`define ICTM_MODE_SRC_LSB 5
`define ICTM_MODE_PRE_LSB 3
`define ICTM_MODE_TAP_LSB 0

// Reset values and constants.
`define ICTM_LINE_EN_RST 10'h000
`define ICTM_EDGE_SEL_RST 8'h00
`define ICTM_SIXTEEN_BIT_TIMER_MODE_RST 8'h00
`define ICTM_STACK_PTR_RST 8'h00
`define ICTM_VECTOR 16'h0010
`define ICTM_STACK_STEP 8'h02

`endif

// *** ictm_pkg.sv ***
// Types of the interrupt controller.
`include "ictm_map.svh"
package ictm_pkg;

    // Core operations.
    typedef enum logic [2:0] {
        OP_IRQ_ENTRY, OP_RETURN, OP_PUSH_AF, OP_POP_AF,
        OP_TIMER_LOAD, OP_TIMER_READ, OP_GIE_ON, OP_GIE_OFF
    } ictm_op_e;

    typedef enum logic [2:0] {ST_IDLE, ST_SECOND, ST_RD_LO, ST_RD_HI, ST_FINISH} ictm_state_e;

    typedef struct packed {
        logic valid;
        ictm_op_e op;
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] flag;
        logic [7:0] addr;
    } ictm_core_req_s;

    typedef struct packed {
        logic done;
        logic pc_load;
        logic [15:0] pc;
        logic af_load;
        logic [7:0] acc;
        logic [7:0] flag;
    } ictm_core_resp_s;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ictm_mem_req_s;

    typedef struct packed {
        logic adc;
        logic tmr2;
        logic tmr3_pwm2;
        logic cmp_pwm1;
        logic pwm0;
        logic touch_overflow_irq;
        logic touch_done_irq;
    } ictm_src_s;

endpackage

// *** ictm_sync.sv ***
// Two-flop synchroniser with edge pulses.
`timescale 1ns/1ns
`default_nettype none
module ictm_sync import ictm_pkg::*; #(
    parameter int W = 6
) (
    input wire logic clk, // Sampling clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic [W-1:0] async_in, // Raw asynchronous levels.
    output logic [W-1:0] rise, // Rising edge pulse.
    output logic [W-1:0] fall // Falling edge pulse.
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // Only the second and third stages are read; the first may be metastable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge pulses.
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// *** ictm_sixteen_bit_timer.sv ***
// Sixteen bit up-counter with prescaler and tap request.
`timescale 1ns/1ns
`default_nettype none
module ictm_sixteen_bit_timer import ictm_pkg::*; (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic [7:0] mode, // Timer mode register.
    input wire logic fall_sel, // Falling tap edge requests.
    input wire logic pin4_tick, // Pin A4 edge pulse.
    input wire logic hrc_tick, // High speed RC edge pulse.
    input wire logic lrc_tick, // Low speed RC edge pulse.
    input wire logic pin0_tick, // Pin A0 edge pulse.
    input wire logic load, // Load pulse.
    input wire logic [15:0] load_val, // Value to load.
    output logic [15:0] count, // Current count.
    output logic irq // One-cycle request pulse.
);
    logic [5:0] psc_q;
    logic [15:0] cnt_q;
    logic tap_q;
    logic irq_q;
    wire [2:0] src = mode[`ICTM_MODE_SRC_LSB +: 3];
    wire [1:0] pre = mode[`ICTM_MODE_PRE_LSB +: 2];
    wire [2:0] tap_sel = mode[`ICTM_MODE_TAP_LSB +: 3];
    wire [7:0] cnt_hi = cnt_q[15:8];

    // Source select; reserved codes behave as stopped.
    wire src_tick = (src == 3'h1) | ((src == 3'h3) & pin4_tick) | ((src == 3'h4) & hrc_tick) | // R15
                    ((src == 3'h6) & lrc_tick) | ((src == 3'h7) & pin0_tick); // R15
    wire [5:0] psc_lim = (pre == 2'h0) ? 6'h00 : (pre == 2'h1) ? 6'h03 : (pre == 2'h2) ? 6'h0f : 6'h3f; // R16
    wire psc_wrap = src_tick & (psc_q >= psc_lim); // R16
    wire tap = cnt_hi[tap_sel]; // R17
    wire tap_edge = fall_sel ? (tap_q & ~tap) : (~tap_q & tap); // R18

    // Prescaler and counter; a load beats a tick.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psc_q <= 6'h00;
            cnt_q <= 16'h0000;
        end else if (ce) begin
            if (src_tick) begin
                psc_q <= psc_wrap ? 6'h00 : psc_q + 6'h01; // R16
            end
            if (load) begin
                cnt_q <= load_val; // R14
            end else if (psc_wrap) begin
                cnt_q <= cnt_q + 16'h0001; // R21 R14
            end
        end
    end

    // Tap history and registered request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (ce) begin
            tap_q <= tap;
            irq_q <= tap_edge; // R18
        end
    end

    assign count = cnt_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// *** ictm_irq_controller.sv ***
// Interrupt controller top: request flags, enables, stack sequencer and register slave.
`timescale 1ns/1ns
`default_nettype none
module ictm_irq_controller import ictm_pkg::*; (
    input wire logic REF_CLK, // System clock, 250 MHz.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic CE, // Clock enable; freezes all state when low.
    input wire logic HSEL, // Slave select.
    input wire logic [31:0] HADDR, // Byte address.
    input wire logic [1:0] HTRANS, // Transfer type.
    input wire logic HWRITE, // Write when high.
    input wire logic [2:0] HSIZE, // Transfer size, word only.
    input wire logic [31:0] HWDATA, // Write data.
    input wire logic HREADY, // Bus ready.
    output logic [31:0] HRDATA, // Read data.
    output logic HREADYOUT, // Slave ready.
    output logic HRESP, // Always OKAY.
    input wire logic PORT_A_PIN0, // External line 0 pin choice A.
    input wire logic PORT_B_PIN5, // External line 0 pin choice B.
    input wire logic PORT_B_PIN0, // External line 1 pin choice A.
    input wire logic PORT_A_PIN4, // External line 1 pin choice B.
    input wire logic HIGH_SPEED_RC_CLOCK, // High speed RC level, sampled.
    input wire logic LOW_SPEED_RC_CLOCK, // Low speed RC level, sampled.
    input wire ictm_src_s SRC_EVENTS, // Same-clock event pulses.
    input wire ictm_core_req_s CORE_REQ, // Core request.
    output ictm_core_resp_s CORE_RESP, // Completion.
    output logic CORE_BUSY, // Operation running.
    output logic IRQ_PENDING, // Request may be taken.
    output ictm_mem_req_s MEM_REQ, // Data memory access.
    input wire logic [7:0] MEM_RDATA // Read data, a cycle after re.
);
    localparam int NL = `ICTM_NUM_LINES;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and the timer.

    logic [5:0] pin_rise;
    logic [5:0] pin_fall;
    logic [15:0] tmr_count;
    logic tmr_irq;
    logic [7:0] timer_mode_q;
    logic [7:0] edge_sel_q;
    logic tload_q;
    logic [15:0] word_q;

    // Pins and oscillators are asynchronous, so all are synchronised.
    ictm_sync #(.W(6)) u_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .async_in({LOW_SPEED_RC_CLOCK, HIGH_SPEED_RC_CLOCK, PORT_A_PIN4, PORT_B_PIN0, PORT_B_PIN5, PORT_A_PIN0}),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Timer; pin and oscillator sources count rising edges.
    ictm_sixteen_bit_timer u_timer (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .mode(timer_mode_q),
        .fall_sel(edge_sel_q[`ICTM_EDGE_TIMER_FALL]), // R18
        .pin4_tick(pin_rise[3]),
        .hrc_tick(pin_rise[4]),
        .lrc_tick(pin_rise[5]),
        .pin0_tick(pin_rise[0]),
        .load(tload_q),
        .load_val(word_q),
        .count(tmr_count),
        .irq(tmr_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register slave.

    logic dp_valid_q;
    logic dp_write_q;
    logic dp_map_q;
    logic [7:0] dp_idx_q;

    // Address phase taken when ready; no wait states.
    wire ap_take = HSEL & HTRANS[1] & HREADY & CE;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_map_q <= 1'b0;
            dp_idx_q <= 8'h00;
        end else if (CE) begin
            dp_valid_q <= ap_take;
            dp_write_q <= HWRITE;
            dp_map_q <= (HADDR[31:10] == 22'h000000) & (HADDR[1:0] == 2'h0);
            dp_idx_q <= HADDR[9:2];
        end
    end

    // Write strobes in the data phase.
    wire wr_en = dp_valid_q & dp_write_q & dp_map_q & CE;
    wire wr_line_en = wr_en & (dp_idx_q == `ICTM_IDX_LINE_EN);
    wire wr_flags = wr_en & (dp_idx_q == `ICTM_IDX_FLAGS);
    wire wr_mode = wr_en & (dp_idx_q == `ICTM_IDX_SIXTEEN_BIT_TIMER_MODE);
    wire wr_edge = wr_en & (dp_idx_q == `ICTM_IDX_EDGE_SEL);
    wire wr_stack = wr_en & (dp_idx_q == `ICTM_IDX_STACK_PTR);

    logic [NL-1:0] line_en_q;
    logic [NL-1:0] flags_q;
    logic [7:0] stack_pointer_q;
    logic gie_q;
    ictm_state_e state_q;

    // Software control registers.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            line_en_q <= `ICTM_LINE_EN_RST;
            timer_mode_q <= `ICTM_SIXTEEN_BIT_TIMER_MODE_RST;
            edge_sel_q <= `ICTM_EDGE_SEL_RST;
        end else if (CE) begin
            if (wr_line_en) begin
                line_en_q <= HWDATA[NL-1:0]; // R2
            end
            if (wr_mode) begin
                timer_mode_q <= HWDATA[7:0]; // R20
            end
            if (wr_edge) begin
                edge_sel_q <= HWDATA[7:0]; // R4
            end
        end
    end

    // Read mux; unmapped and reserved bits read zero.
    wire [31:0] rd_word =
        (dp_idx_q == `ICTM_IDX_LINE_EN) ? {22'h000000, line_en_q} :
        (dp_idx_q == `ICTM_IDX_FLAGS) ? {22'h000000, flags_q} : // R11
        (dp_idx_q == `ICTM_IDX_SIXTEEN_BIT_TIMER_MODE) ? {24'h000000, timer_mode_q} : // R20
        (dp_idx_q == `ICTM_IDX_EDGE_SEL) ? {24'h000000, edge_sel_q} :
        (dp_idx_q == `ICTM_IDX_STACK_PTR) ? {24'h000000, stack_pointer_q} :
        (dp_idx_q == `ICTM_IDX_STATUS) ? {30'h00000000, (state_q != ST_IDLE), gie_q} :
        (dp_idx_q == `ICTM_IDX_COUNT) ? {16'h0000, tmr_count} : 32'h00000000;

    assign HRDATA = (dp_valid_q & ~dp_write_q & dp_map_q) ? rd_word : 32'h00000000;
    assign HREADYOUT = CE;
    assign HRESP = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Request sources and flags.

    // Edge mode: 01 rising, 10 falling, otherwise both.
    function automatic logic edge_hit(input logic [1:0] md, input logic r, input logic f);
        edge_hit = (md == 2'h1) ? r : (md == 2'h2) ? f : (r | f);
    endfunction

    // Each shared line picks one of two pins.
    wire ext0_sel = edge_sel_q[`ICTM_EDGE_EXT0_PINSEL];
    wire ext1_sel = edge_sel_q[`ICTM_EDGE_EXT1_PINSEL];
    wire ext0_r = ext0_sel ? pin_rise[1] : pin_rise[0];
    wire ext0_f = ext0_sel ? pin_fall[1] : pin_fall[0];
    wire ext1_r = ext1_sel ? pin_rise[3] : pin_rise[2];
    wire ext1_f = ext1_sel ? pin_fall[3] : pin_fall[2];
    wire ext0_ev = edge_hit(edge_sel_q[`ICTM_EDGE_EXT0_LSB +: 2], ext0_r, ext0_f); // R4
    wire ext1_ev = edge_hit(edge_sel_q[`ICTM_EDGE_EXT1_LSB +: 2], ext1_r, ext1_f); // R4

    // One event per request line, in flag bit order.
    wire [NL-1:0] line_ev = {
        SRC_EVENTS.touch_done_irq, SRC_EVENTS.touch_overflow_irq, SRC_EVENTS.pwm0, // R1
        SRC_EVENTS.cmp_pwm1, SRC_EVENTS.tmr3_pwm2, SRC_EVENTS.tmr2, SRC_EVENTS.adc, // R1
        tmr_irq, ext1_ev, ext0_ev // R19
    };

    // Flags ignore enables; a zero write clears, a new event wins.
    logic [NL-1:0] flags_d;
    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++) begin : g_flag
            assign flags_d[gi] = line_ev[gi] | (flags_q[gi] & ~(wr_flags & ~HWDATA[gi])); // R3 R6
        end
    endgenerate

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_q <= '0;
        end else if (CE) begin
            flags_q <= flags_d; // R3
        end
    end

    // Offered only when enabled, globally allowed and idle.
    wire any_req = |(flags_q & line_en_q); // R2
    assign IRQ_PENDING = gie_q & any_req & (state_q == ST_IDLE); // R5

    ////////////////////////////////////////////////////////////////////////////
    // Stack and timer transfer sequencer.

    ictm_op_e op_q;
    ictm_op_e op_d;
    ictm_state_e state_d;
    logic [7:0] base_q;
    logic [7:0] base_d;
    logic [15:0] word_d;
    ictm_mem_req_s mem_q;
    ictm_mem_req_s mem_d;
    ictm_core_resp_s resp_q;
    ictm_core_resp_s resp_d;
    logic gie_d;
    logic [7:0] stack_d;
    logic tload_d;

    // Entry is refused while the global enable is clear.
    wire req_ok = CORE_REQ.valid & ((CORE_REQ.op != OP_IRQ_ENTRY) | gie_q); // R5
    wire op_is_wr = (op_q == OP_IRQ_ENTRY) | (op_q == OP_PUSH_AF) | (op_q == OP_TIMER_READ);
    wire req_is_wr = (CORE_REQ.op == OP_IRQ_ENTRY) | (CORE_REQ.op == OP_PUSH_AF) |
                     (CORE_REQ.op == OP_TIMER_READ);
    wire [7:0] stack_up = stack_pointer_q + `ICTM_STACK_STEP;
    wire [7:0] stack_dn = stack_pointer_q - `ICTM_STACK_STEP;

    // First byte: pushes at the pointer, pops two below.
    wire [7:0] req_base =
        ((CORE_REQ.op == OP_IRQ_ENTRY) | (CORE_REQ.op == OP_PUSH_AF)) ? stack_pointer_q : // R7 R10
        ((CORE_REQ.op == OP_RETURN) | (CORE_REQ.op == OP_POP_AF)) ? stack_dn : CORE_REQ.addr; // R8 R10

    // Word to store.
    wire [15:0] req_word =
        (CORE_REQ.op == OP_IRQ_ENTRY) ? CORE_REQ.pc : // R7
        (CORE_REQ.op == OP_PUSH_AF) ? {CORE_REQ.flag, CORE_REQ.acc} : tmr_count; // R10 R14

    // Next state; the pointer moves only once the word is done.
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        base_d = base_q;
        word_d = word_q;
        mem_d = '0;
        resp_d = '0;
        gie_d = gie_q;
        stack_d = wr_stack ? HWDATA[7:0] : stack_pointer_q;
        tload_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (req_ok) begin
                    if (CORE_REQ.op == OP_GIE_ON) begin
                        gie_d = 1'b1; // R5
                        resp_d.done = 1'b1;
                    end else if (CORE_REQ.op == OP_GIE_OFF) begin
                        gie_d = 1'b0; // R5
                        resp_d.done = 1'b1;
                    end else begin
                        op_d = CORE_REQ.op;
                        base_d = req_base;
                        word_d = req_word;
                        mem_d.we = req_is_wr;
                        mem_d.re = ~req_is_wr;
                        mem_d.addr = req_base;
                        mem_d.wdata = req_word[7:0];
                        state_d = ST_SECOND;
                    end
                end
            end
            ST_SECOND: begin
                mem_d.we = op_is_wr;
                mem_d.re = ~op_is_wr;
                mem_d.addr = base_q + 8'h01;
                mem_d.wdata = word_q[15:8];
                state_d = op_is_wr ? ST_FINISH : ST_RD_LO;
            end
            ST_RD_LO: begin
                word_d[7:0] = MEM_RDATA;
                state_d = ST_RD_HI;
            end
            ST_RD_HI: begin
                word_d[15:8] = MEM_RDATA;
                state_d = ST_FINISH;
            end
            ST_FINISH: begin
                state_d = ST_IDLE;
                resp_d.done = 1'b1;
                unique case (op_q)
                    OP_IRQ_ENTRY: begin
                        stack_d = stack_up; // R7
                        gie_d = 1'b0; // R7
                        resp_d.pc_load = 1'b1;
                        resp_d.pc = `ICTM_VECTOR; // R7
                    end
                    OP_RETURN: begin
                        stack_d = stack_dn; // R8
                        gie_d = 1'b1; // R8
                        resp_d.pc_load = 1'b1;
                        resp_d.pc = word_q; // R8
                    end
                    OP_PUSH_AF: begin
                        stack_d = stack_up; // R10
                    end
                    OP_POP_AF: begin
                        stack_d = stack_dn; // R10
                        resp_d.af_load = 1'b1;
                        resp_d.acc = word_q[7:0];
                        resp_d.flag = word_q[15:8];
                    end
                    OP_TIMER_LOAD: begin
                        tload_d = 1'b1; // R14
                    end
                    default: begin
                        resp_d.pc_load = 1'b0;
                    end
                endcase
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            op_q <= OP_IRQ_ENTRY;
            base_q <= 8'h00;
            word_q <= 16'h0000;
        end else if (CE) begin
            state_q <= state_d;
            op_q <= op_d;
            base_q <= base_d;
            word_q <= word_d;
        end
    end

    // Architectural state and registered outputs.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gie_q <= 1'b0;
            stack_pointer_q <= `ICTM_STACK_PTR_RST;
            mem_q <= '0;
            resp_q <= '0;
            tload_q <= 1'b0;
        end else if (CE) begin
            gie_q <= gie_d;
            stack_pointer_q <= stack_d;
            mem_q <= mem_d;
            resp_q <= resp_d;
            tload_q <= tload_d;
        end
    end

    assign MEM_REQ = mem_q;
    assign CORE_RESP = resp_q;
    assign CORE_BUSY = (state_q != ST_IDLE);
endmodule
`default_nettype wire

// *** ictm_chk_asserts.sv ***
// Port checker of the interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module ictm_chk import ictm_pkg::*; (
    input wire logic REF_CLK, // Clock.
    input wire logic RST_N, // Reset.
    input wire logic CE, // Enable.
    input wire logic HREADYOUT, // Ready.
    input wire logic HRESP, // Response.
    input wire ictm_core_req_s CORE_REQ, // Request.
    input wire ictm_core_resp_s CORE_RESP, // Answer.
    input wire logic CORE_BUSY, // Busy.
    input wire logic IRQ_PENDING, // Pending.
    input wire ictm_mem_req_s MEM_REQ // Memory.
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Requests count only while idle, since busy ones are dropped.
    wire logic go = CORE_REQ.valid && !CORE_BUSY && CE;
    wire logic ent = go && CORE_REQ.op == OP_IRQ_ENTRY && IRQ_PENDING;
    wire logic ret = go && CORE_REQ.op == OP_RETURN;
    ////////////////////////////////////////
    bus_ready_a: assert property (HREADYOUT == CE) else $error("ready");
    bus_okay_a: assert property (!HRESP) else $error("resp");
    entry_push_a: assert property (ent |=> MEM_REQ.we && MEM_REQ.wdata == $past(CORE_REQ.pc[7:0])
        ##1 MEM_REQ.we && MEM_REQ.addr == $past(MEM_REQ.addr) + 8'h01) else $error("push");
    entry_vector_a: assert property (ent |-> ##[3:4] CORE_RESP.done && CORE_RESP.pc == 16'h0010)
        else $error("vector");
    return_pop_a: assert property (ret |=> MEM_REQ.re ##1 MEM_REQ.re
        && MEM_REQ.addr == $past(MEM_REQ.addr) + 8'h01) else $error("pop");
    return_done_a: assert property (ret |-> ##[5:6] CORE_RESP.done && CORE_RESP.pc_load)
        else $error("return");
    af_push_a: assert property (go && CORE_REQ.op == OP_PUSH_AF |=> MEM_REQ.wdata == $past(CORE_REQ.acc)
        ##1 MEM_REQ.we && MEM_REQ.wdata == $past(CORE_REQ.flag, 2)) else $error("af");
    gie_off_a: assert property (go && CORE_REQ.op == OP_GIE_OFF |-> ##2 !IRQ_PENDING)
        else $error("gie");
endmodule
bind ictm_irq_controller ictm_chk u_chk (.REF_CLK, .RST_N, .CE, .HREADYOUT, .HRESP, .CORE_REQ,
    .CORE_RESP, .CORE_BUSY, .IRQ_PENDING, .MEM_REQ);
`default_nettype wire

// *** ictm_mem_model.sv ***
// Data memory of the core, holding the stack.
`timescale 1ns/1ns
`default_nettype none
module ictm_mem_model import ictm_pkg::*; (
    input wire logic clk, // Clock.
    input wire ictm_mem_req_s req, // Access.
    output logic [7:0] rdata // Read data, next cycle.
);
    logic [7:0] mem [256];
    initial rdata = 8'h00;
    // Between reads the data toggles, so a late sample fails.
    always @(posedge clk) begin
        if (req.we) mem[req.addr] <= req.wdata;
        rdata <= req.re ? mem[req.addr] : ~rdata;
    end
endmodule
`default_nettype wire

// *** test_irq_controller_with_sixteen_bit_timer.sv ***
// Bench of the interrupt controller with its timer.
`timescale 1ns/1ns
`default_nettype none
module test_irq_controller_with_sixteen_bit_timer import ictm_pkg::*;;
    logic clk = 0, rst_n = 0, sel = 0, wr = 0, pb5 = 0, sq_on = 0, rdy, pend;
    logic [1:0] trn = 0;
    logic [7:0] sq = 0;
    logic [31:0] addr = 0, wd = 0, rd, hr;
    logic [15:0] c0;
    logic [23:0] tc [9] = '{24'h280f12, 24'h300306, 24'h380102, 24'h400000, 24'h60070a, 24'h80070a,
        24'ha00000, 24'hc0070a, 24'he0070a};
    ictm_src_s ev = '0;
    ictm_core_req_s req = '0;
    ictm_core_resp_s rsp, cr;
    ictm_mem_req_s mq;
    logic [7:0] mrd;
    int err_count = 0, cmp_count = 0;
    ictm_irq_controller uut (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1), .HSEL(sel), .HADDR(addr),
        .HTRANS(trn), .HWRITE(wr), .HSIZE(3'h2), .HWDATA(wd), .HREADY(rdy), .HRDATA(hr),
        .HREADYOUT(rdy), .HRESP(), .PORT_A_PIN0(sq[2]), .PORT_B_PIN5(pb5), .PORT_B_PIN0(1'b0),
        .PORT_A_PIN4(sq[2]), .HIGH_SPEED_RC_CLOCK(sq[2]), .LOW_SPEED_RC_CLOCK(sq[2]),
        .SRC_EVENTS(ev), .CORE_REQ(req), .CORE_RESP(rsp), .CORE_BUSY(), .IRQ_PENDING(pend),
        .MEM_REQ(mq), .MEM_RDATA(mrd));
    ictm_mem_model mem_i (.clk(clk), .req(mq), .rdata(mrd));
    initial forever #2 clk = ~clk;
    // Slow square wave on pins and oscillators.
    always @(posedge clk) if (sq_on) sq <= sq + 8'h01;
    ////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    // Waits for ready or done; a hang ends the run.
    task automatic wt(input bit core);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((core ? rsp.done : rdy) !== 1'b1 && n < 50);
        cr = rsp;
        if (n >= 50) begin
            err_count++;
            give_verdict;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
        sel <= 1'b1;
        trn <= 2'b10;
        wr <= w;
        addr <= {22'h0, i, 2'b00};
        wt(1'b0);
        sel <= 1'b0;
        trn <= 2'b00;
        wd <= d;
        wt(1'b0);
        rd = hr;
    endtask
    task automatic rc(input string n, input logic [7:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        chk(n, rd, e);
    endtask
    task automatic core(input ictm_op_e op, input logic [15:0] pc, input logic [7:0] a);
        req <= '{1'b1, op, pc, 8'h5a, 8'ha5, a};
        @(posedge clk);
        req.valid <= 1'b0;
        wt(1'b1);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 4; i < 12; i++) rc("reset", 8'(i), 32'h0);
        bus(1'b1, 8'h30, 32'hffffffff);
        rc("unmapped", 8'h30, 32'h0);
        bus(1'b1, 8'h06, 32'hbd);
        rc("mode", 8'h06, 32'hbd);
        bus(1'b1, 8'h06, 32'h0);
        $display("end registers");
        ev <= 7'h7f;
        @(posedge clk);
        ev <= 7'h00;
        rc("flags", 8'h05, 32'h3f8);
        chk("masked", pend, 1'b0);
        bus(1'b1, 8'h05, 32'h1ff);
        rc("clear", 8'h05, 32'h1f8);
        bus(1'b1, 8'h04, 32'h008);
        chk("no gie", pend, 1'b0);
        core(OP_GIE_ON, 16'h0, 8'h00);
        @(posedge clk);
        chk("gie", pend, 1'b1);
        bus(1'b1, 8'h07, 32'h41);
        pb5 <= 1'b1;
        repeat (8) @(posedge clk);
        rc("rise", 8'h05, 32'h1f9);
        bus(1'b1, 8'h05, 32'h3fe);
        pb5 <= 1'b0;
        repeat (8) @(posedge clk);
        rc("fall", 8'h05, 32'h1f8);
        $display("end flags");
        bus(1'b1, 8'h08, 32'h40);
        core(OP_IRQ_ENTRY, 16'h1234, 8'h00);
        chk("vector", cr.pc, 16'h0010);
        chk("stack", {mem_i.mem[8'h41], mem_i.mem[8'h40]}, 16'h1234);
        rc("sp up", 8'h08, 32'h42);
        rc("gie off", 8'h09, 32'h0);
        core(OP_PUSH_AF, 16'h0, 8'h00);
        chk("af", {mem_i.mem[8'h42], mem_i.mem[8'h43]}, 16'h5aa5);
        core(OP_POP_AF, 16'h0, 8'h00);
        chk("pop", {cr.af_load, cr.acc, cr.flag}, 17'h15aa5);
        core(OP_RETURN, 16'h0, 8'h00);
        chk("resume", cr.pc, 16'h1234);
        rc("sp down", 8'h08, 32'h40);
        rc("gie on", 8'h09, 32'h1);
        $display("end stack");
        mem_i.mem[8'h80] = 8'hf0;
        mem_i.mem[8'h81] = 8'h00;
        core(OP_TIMER_LOAD, 16'h0, 8'h80);
        @(posedge clk);
        rc("load", 8'h0a, 32'hf0);
        core(OP_TIMER_READ, 16'h0, 8'h90);
        chk("store", {mem_i.mem[8'h91], mem_i.mem[8'h90]}, 16'h00f0);
        bus(1'b1, 8'h05, 32'h0);
        bus(1'b1, 8'h06, 32'h21);
        repeat (40) @(posedge clk);
        rc("tap early", 8'h05, 32'h0);
        repeat (300) @(posedge clk);
        rc("tap", 8'h05, 32'h4);
        bus(1'b1, 8'h06, 32'h0);
        foreach (tc[k]) begin
            bus(1'b0, 8'h0a, 32'h0);
            c0 = rd[15:0];
            rc("stopped", 8'h0a, {16'h0, c0});
            sq_on <= 1'b1;
            bus(1'b1, 8'h06, {24'h0, tc[k][23:16]});
            repeat (64) @(posedge clk);
            bus(1'b1, 8'h06, 32'h0);
            sq_on <= 1'b0;
            bus(1'b0, 8'h0a, 32'h0);
            chk("ticks", rd[15:0] - c0 inside {[tc[k][15:8]:tc[k][7:0]]}, 1'b1);
        end
        core(OP_GIE_OFF, 16'h0, 8'h00);
        rc("gie clear", 8'h09, 32'h0);
        $display("end timer");
        give_verdict;
    end
endmodule
`default_nettype wire
